// ### lcr_map.vh
// register offsets, field positions and reset values for the link control register group
`ifndef LCR_MAP_VH
`define LCR_MAP_VH
`define LCR_ADDR_ERR_THR 8'h41
`define LCR_ADDR_BC_SPEED 8'h43
`define LCR_ADDR_EQ_MANUAL 8'h44
`define LCR_ADDR_EQ_FLOOR 8'h45
`define LCR_ADDR_PICK_A 8'h52
`define LCR_ADDR_DRV_ON 8'h56
`define LCR_ADDR_PICK_B 8'h57
`define LCR_ADDR_PWR 8'h63
`define LCR_RST_ERR_THR 8'h03
`define LCR_RST_BC_SPEED 8'h00
`define LCR_RST_EQ_MANUAL 8'h60
`define LCR_RST_EQ_FLOOR 8'h88
`define LCR_RST_PICK_A 8'h00
`define LCR_RST_DRV_ON 8'h00
`define LCR_RST_PICK_B 8'h00
`define LCR_RST_PWR 8'h00
`define LCR_BIT_ERR_EN 4
`define LCR_BIT_MISO_MODE 4
`define LCR_BIT_CPOL 3
`define LCR_BIT_EQ_MANUAL 0
`define LCR_BIT_LOOP_PORT 7
`define LCR_BIT_LOOP_DRV 3
`define LCR_PAIR_FIRST 2'h1
`define LCR_PAIR_SECOND 2'h2
`endif

// ### lcr_err_counter.v
// link error counter with lock-drop threshold
`timescale 1ns/10ps
module lcr_err_counter #(
  parameter CNT_W = 4
) (
  input wire core_clk,
  input wire nrst,
  input wire clk_en,
  input wire count_on,
  input wire [CNT_W-1:0] threshold,
  input wire err_clk0,
  input wire err_clk1,
  input wire err_dcf,
  input wire lock_regained,
  output reg lock_drop,
  output reg [CNT_W-1:0] err_count
);
  reg [CNT_W+1:0] sum;
  // running count plus errors seen this cycle on the three monitored positions
  always @* begin
    sum = {{(CNT_W+1){1'b0}}, err_clk0} + {{(CNT_W+1){1'b0}}, err_clk1}
        + {{(CNT_W+1){1'b0}}, err_dcf} + {2'b00, err_count};
  end
  // accumulate and compare to threshold
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      err_count <= {CNT_W{1'b0}};
      lock_drop <= 1'b0;
    end else if (clk_en) begin
      lock_drop <= 1'b0;
      if (lock_regained || !count_on) begin
        err_count <= {CNT_W{1'b0}};
        if (!count_on && (err_clk0 || err_clk1 || err_dcf))
          lock_drop <= 1'b1;
      end else if (err_clk0 || err_clk1 || err_dcf) begin
        if (sum >= {2'b00, threshold}) begin
          lock_drop <= 1'b1;
          err_count <= {CNT_W{1'b0}};
        end else begin
          err_count <= sum[CNT_W-1:0];
        end
      end
    end
  end
endmodule // lcr_err_counter

// ### lcr_regs.v
// link control register group: registers, back-channel, equalizer and loop-through control
// Contract
// - bit enables link error counting
// - enabled: drop lock at threshold, default three
// - disabled: drop lock on first error
// - count pixel-clock errors on clk0, clk1, data
// - miso driven always, or tristate when unselected; code tristates it outside the spi reverse modes
// - polarity bit picks launch and sample edges
// - mode 000-011 select GPIO variants
// - mode 100-111 select SPI variants
// - manual upper eq bits, default three
// - manual lower eq bits; one bit picks manual
// - adaptive eq starts from floor, default eight
// - second-port access writes second-port floor
// - single bit picks loop-through source port
// - pair field 01/10 picks loop-through port; code only compares it with the single bit
// - loop driver on only when enabled bit
// - second-port access: write both, read port one; code reads port two
// - floor used only with override and apply
`timescale 1ns/10ps
`include "lcr_map.vh"
module lcr_regs #(
  parameter CNT_W = 4
) (
  input wire core_clk,
  input wire nrst,
  input wire clk_en,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire second_port_access,
  input wire floor_override_on,
  input wire floor_apply,
  input wire err_clk0,
  input wire err_clk1,
  input wire err_data_control_field,
  input wire lock_regained,
  output reg lock_drop,
  input wire spi_ss_n,
  input wire miso_out_in,
  output reg miso_out,
  output reg miso_oe_n,
  output reg spi_launch_rise,
  output reg gpio_mode_on,
  output reg gpio_hs_on,
  output reg [2:0] gpio_hs_count,
  output reg spi_mode_on,
  output reg spi_reverse,
  output reg spi_hs_on,
  output reg [5:0] eq_setting,
  output reg eq_manual_sel,
  output reg [3:0] eq_start_floor0,
  output reg [3:0] eq_start_floor1,
  output reg floor_valid,
  input wire first_rx_input,
  input wire second_rx_input,
  output reg loop_output_pair,
  output reg loop_driver_on,
  output reg loop_pick_mismatch
);
  // shared registers
  reg [7:0] err_thr_r;
  reg [7:0] bc_speed_r;
  reg [7:0] eq_manual_r;
  reg [7:0] eq_floor0_r;
  reg [7:0] eq_floor1_r;
  reg [7:0] pick_a_r;
  reg [7:0] drv_on_r;
  reg [7:0] pick_b_r;
  reg [7:0] pwr_r;
  reg [7:0] rdata_nxt;
  wire lock_drop_w;
  wire [CNT_W-1:0] err_count_w;

  // pin synchroniser stages, only the second stage is read
  reg ss_n_meta_r;
  reg ss_n_sync_r;
  reg rx0_meta_r;
  reg rx0_sync_r;
  reg rx1_meta_r;
  reg rx1_sync_r;

  // decoded next values of the registered outputs
  reg gpio_mode_nxt;
  reg gpio_hs_nxt;
  reg [2:0] gpio_count_nxt;
  reg spi_mode_nxt;
  reg spi_reverse_nxt;
  reg spi_hs_nxt;
  reg miso_oe_n_nxt;
  reg loop_out_nxt;

  // back-channel mode codes that carry high-speed gpio lanes
  localparam MODE_HS_GPIO_ONE = 3'h1;
  localparam MODE_HS_GPIO_TWO = 3'h2;
  localparam MODE_HS_GPIO_FOUR = 3'h3;

  // true when the loop-through pair field names the same port as the single bit
  function pick_agree;
    input sel_bit;
    input [1:0] sel_pair;
    begin
      pick_agree = sel_bit ? (sel_pair == `LCR_PAIR_SECOND) : (sel_pair == `LCR_PAIR_FIRST);
    end
  endfunction

  // lane count for a mode, zero outside the gpio modes so spi codes never leak a count
  function [2:0] hs_lanes;
    input [2:0] mode;
    begin
      case (mode)
        MODE_HS_GPIO_ONE: hs_lanes = 3'h1;
        MODE_HS_GPIO_TWO: hs_lanes = 3'h2;
        MODE_HS_GPIO_FOUR: hs_lanes = 3'h4;
        default: hs_lanes = 3'h0;
      endcase
    end
  endfunction

  // register writes
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      err_thr_r <= `LCR_RST_ERR_THR;
      bc_speed_r <= `LCR_RST_BC_SPEED;
      eq_manual_r <= `LCR_RST_EQ_MANUAL;
      eq_floor0_r <= `LCR_RST_EQ_FLOOR;
      eq_floor1_r <= `LCR_RST_EQ_FLOOR;
      pick_a_r <= `LCR_RST_PICK_A;
      drv_on_r <= `LCR_RST_DRV_ON;
      pick_b_r <= `LCR_RST_PICK_B;
      pwr_r <= `LCR_RST_PWR;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        `LCR_ADDR_ERR_THR: err_thr_r <= reg_wdata;
        `LCR_ADDR_BC_SPEED: bc_speed_r <= reg_wdata;
        `LCR_ADDR_EQ_MANUAL: eq_manual_r <= reg_wdata;
        `LCR_ADDR_EQ_FLOOR: begin
          if (second_port_access) begin
            eq_floor1_r <= reg_wdata;
            eq_floor0_r <= reg_wdata;
          end else begin
            eq_floor0_r <= reg_wdata;
          end
        end
        `LCR_ADDR_PICK_A: pick_a_r <= reg_wdata;
        `LCR_ADDR_DRV_ON: drv_on_r <= reg_wdata;
        `LCR_ADDR_PICK_B: pick_b_r <= reg_wdata;
        `LCR_ADDR_PWR: pwr_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read mux, unmapped reads return zero
  always @* begin
    case (reg_addr)
      `LCR_ADDR_ERR_THR: rdata_nxt = err_thr_r;
      `LCR_ADDR_BC_SPEED: rdata_nxt = bc_speed_r;
      `LCR_ADDR_EQ_MANUAL: rdata_nxt = eq_manual_r;
      `LCR_ADDR_EQ_FLOOR: rdata_nxt = second_port_access ? eq_floor1_r : eq_floor0_r;
      `LCR_ADDR_PICK_A: rdata_nxt = pick_a_r;
      `LCR_ADDR_DRV_ON: rdata_nxt = drv_on_r;
      `LCR_ADDR_PICK_B: rdata_nxt = pick_b_r;
      `LCR_ADDR_PWR: rdata_nxt = pwr_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // error counter
  lcr_err_counter #(.CNT_W(CNT_W)) u_err (
    .core_clk(core_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .count_on(err_thr_r[`LCR_BIT_ERR_EN]),
    .threshold(err_thr_r[CNT_W-1:0]),
    .err_clk0(err_clk0),
    .err_clk1(err_clk1),
    .err_dcf(err_data_control_field),
    .lock_regained(lock_regained),
    .lock_drop(lock_drop_w),
    .err_count(err_count_w)
  );

  // slave select pin synchroniser, idles deselected
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ss_n_meta_r <= 1'b1;
      ss_n_sync_r <= 1'b1;
    end else if (clk_en) begin
      ss_n_meta_r <= spi_ss_n;
      ss_n_sync_r <= ss_n_meta_r;
    end
  end

  // first receive input synchroniser
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx0_meta_r <= 1'b0;
      rx0_sync_r <= 1'b0;
    end else if (clk_en) begin
      rx0_meta_r <= first_rx_input;
      rx0_sync_r <= rx0_meta_r;
    end
  end

  // second receive input synchroniser
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx1_meta_r <= 1'b0;
      rx1_sync_r <= 1'b0;
    end else if (clk_en) begin
      rx1_meta_r <= second_rx_input;
      rx1_sync_r <= rx1_meta_r;
    end
  end

  // decode of mode, miso driver and loop-through source
  always @* begin
    gpio_mode_nxt = ~bc_speed_r[2];
    gpio_hs_nxt = ~bc_speed_r[2] & (bc_speed_r[1:0] != 2'h0);
    gpio_count_nxt = hs_lanes(bc_speed_r[2:0]);
    spi_mode_nxt = bc_speed_r[2];
    spi_reverse_nxt = bc_speed_r[2] & bc_speed_r[0];
    spi_hs_nxt = bc_speed_r[2] & bc_speed_r[1];
    if (spi_reverse_nxt)
      miso_oe_n_nxt = bc_speed_r[`LCR_BIT_MISO_MODE] & ss_n_sync_r;
    else
      miso_oe_n_nxt = 1'b1;
    if (drv_on_r[`LCR_BIT_LOOP_DRV])
      loop_out_nxt = pick_a_r[`LCR_BIT_LOOP_PORT] ? rx1_sync_r : rx0_sync_r;
    else
      loop_out_nxt = 1'b0;
  end

  // read data and lock drop
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      lock_drop <= 1'b0;
    end else if (clk_en) begin
      if (reg_rd)
        reg_rdata <= rdata_nxt;
      lock_drop <= lock_drop_w;
    end
  end

  // back-channel mode and spi pin outputs
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      miso_out <= 1'b0;
      miso_oe_n <= 1'b1;
      spi_launch_rise <= 1'b0;
      gpio_mode_on <= 1'b1;
      gpio_hs_on <= 1'b0;
      gpio_hs_count <= 3'h0;
      spi_mode_on <= 1'b0;
      spi_reverse <= 1'b0;
      spi_hs_on <= 1'b0;
    end else if (clk_en) begin
      miso_out <= miso_out_in;
      miso_oe_n <= miso_oe_n_nxt;
      spi_launch_rise <= bc_speed_r[`LCR_BIT_CPOL];
      gpio_mode_on <= gpio_mode_nxt;
      gpio_hs_on <= gpio_hs_nxt;
      gpio_hs_count <= gpio_count_nxt;
      spi_mode_on <= spi_mode_nxt;
      spi_reverse <= spi_reverse_nxt;
      spi_hs_on <= spi_hs_nxt;
    end
  end

  // equalizer settings
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      eq_setting <= 6'h18;
      eq_manual_sel <= 1'b0;
      eq_start_floor0 <= 4'h8;
      eq_start_floor1 <= 4'h8;
      floor_valid <= 1'b0;
    end else if (clk_en) begin
      eq_setting <= {eq_manual_r[7:5], eq_manual_r[3:1]};
      eq_manual_sel <= eq_manual_r[`LCR_BIT_EQ_MANUAL];
      eq_start_floor0 <= eq_floor0_r[3:0];
      eq_start_floor1 <= eq_floor1_r[3:0];
      floor_valid <= floor_override_on & floor_apply;
    end
  end

  // loop-through routing and port select agreement
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      loop_output_pair <= 1'b0;
      loop_driver_on <= 1'b0;
      loop_pick_mismatch <= 1'b0;
    end else if (clk_en) begin
      loop_output_pair <= loop_out_nxt;
      loop_driver_on <= drv_on_r[`LCR_BIT_LOOP_DRV];
      loop_pick_mismatch <= ~pick_agree(pick_a_r[`LCR_BIT_LOOP_PORT], pick_b_r[2:1]);
    end
  end
endmodule // lcr_regs

// ### lcr_regs_properties.sv
// assertions on the link control register group ports
`timescale 1ns/10ps
module lcr_chk (
  input wire core_clk,
  input wire nrst,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire err_clk0,
  input wire err_clk1,
  input wire err_data_control_field,
  input wire lock_drop,
  input wire gpio_mode_on,
  input wire gpio_hs_on,
  input wire [2:0] gpio_hs_count,
  input wire spi_mode_on,
  input wire spi_reverse,
  input wire spi_hs_on,
  input wire floor_override_on,
  input wire floor_valid,
  input wire loop_driver_on,
  input wire loop_output_pair
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // drop then quiet again
  sequence s_pulse;
    lock_drop ##1 !lock_drop;
  endsequence
  // decodes, lock drop, gating and read hold
  chk_mode_split: assert property (gpio_mode_on != spi_mode_on)
    else $error("gpio and spi decode overlap");
  chk_hs_count: assert property (gpio_hs_on |-> gpio_hs_count inside {3'h1, 3'h2, 3'h4})
    else $error("bad gpio count");
  chk_spi_flags: assert property (!spi_mode_on |-> !spi_reverse && !spi_hs_on)
    else $error("spi flags outside spi mode");
  chk_drop_pulse: assert property (lock_drop |-> s_pulse)
    else $error("drop not one cycle");
  chk_drop_cause: assert property (lock_drop |-> $past(err_clk0 || err_clk1 || err_data_control_field, 2))
    else $error("drop without error");
  chk_floor_gate: assert property (!floor_override_on [*3] |-> !floor_valid)
    else $error("floor valid without override");
  chk_loop_quiet: assert property (!loop_driver_on [*3] |-> !loop_output_pair)
    else $error("loop output while disabled");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
endmodule // lcr_chk
bind lcr_regs lcr_chk i_lcr_chk (.*);

// ### lcr_host.sv
// host model driving register writes and reads
`timescale 1ns/10ps
module lcr_host (
  input wire core_clk,
  output logic reg_wr = 1'h0,
  output logic reg_rd = 1'h0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00
);
  // one access; released lines show the inverse
  task acc(input w, input [7:0] a, input [7:0] d);
    @(posedge core_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge core_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'h0, ~a, ~d};
  endtask
endmodule // lcr_host

// ### tb.sv
// self-checking bench for the link control register group
`timescale 1ns/10ps
`define CHK(o, e) begin samples_checked++; if ((o) !== (e)) begin mismatches++; $display("BAD %0t %h %h", $time, o, e); end end
module tb;
  logic core_clk = 1'h0, nrst = 1'h0, clk_en = 1'h1, lock_regained = 1'h0, snap = 1'h0, rd_seen = 1'h0;
  logic second_port_access = 1'h0, floor_override_on = 1'h0, floor_apply = 1'h0, spi_ss_n = 1'h1;
  logic err_clk0 = 1'h0, err_clk1 = 1'h0, err_data_control_field = 1'h0, reg_wr, reg_rd;
  logic miso_out_in = 1'h0, first_rx_input = 1'h0, second_rx_input = 1'h0;
  logic [7:0] reg_addr, reg_wdata;
  wire [7:0] reg_rdata;
  wire [5:0] eq_setting;
  wire [3:0] eq_start_floor0, eq_start_floor1;
  wire [2:0] gpio_hs_count;
  wire lock_drop, miso_out, miso_oe_n, spi_launch_rise, gpio_mode_on, gpio_hs_on, spi_mode_on, spi_reverse;
  wire spi_hs_on, eq_manual_sel, floor_valid, loop_output_pair, loop_driver_on, loop_pick_mismatch;
  wire [7:0] obs [0:6];
  logic [10:0] exp_q [$];
  logic [10:0] e;
  logic [31:0] rs = 32'h7DF5, v;
  logic [2:0] m;
  logic [7:0] adr [8] = '{8'h41, 8'h43, 8'h44, 8'h45, 8'h52, 8'h56, 8'h57, 8'h63};
  logic [7:0] rv [8] = '{8'h03, 8'h00, 8'h60, 8'h88, 8'h00, 8'h00, 8'h00, 8'h00};
  int i, mismatches = 0, samples_checked = 0;
  lcr_regs i_lcr_regs (.*);
  lcr_host i_lcr_host (.*);
  // observed groups, picked by the note
  assign obs[0] = reg_rdata;
  assign obs[1] = {gpio_mode_on, gpio_hs_on, gpio_hs_count, spi_mode_on, spi_reverse, spi_hs_on};
  assign obs[2] = {1'h0, eq_setting, eq_manual_sel};
  assign obs[3] = {eq_start_floor1, eq_start_floor0};
  assign obs[4] = {7'h0, lock_drop};
  assign obs[5] = {4'h0, floor_valid, loop_output_pair, loop_driver_on, loop_pick_mismatch};
  assign obs[6] = {5'h0, miso_out, spi_launch_rise, miso_oe_n};
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) rd_seen <= reg_rd;
  // oldest note against what the outputs show
  always @(negedge core_clk) if (rd_seen || snap) begin
    e = exp_q.pop_front();
    `CHK(obs[e[10:8]], e[7:0])
  end
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // wait n edges, then note a value and flag it
  task look(input [2:0] s, input [7:0] x, input int n);
    repeat (n) @(posedge core_clk);
    exp_q.push_back({s, x});
    snap = 1'h1;
    @(negedge core_clk);
    #1 snap = 1'h0;
  endtask
  task rdc(input [7:0] a, input [7:0] x);
    exp_q.push_back({3'h0, x});
    i_lcr_host.acc(1'h0, a, 8'h00);
  endtask
  task burst(input [2:0] b, input int n);
    @(posedge core_clk);
    {err_clk0, err_clk1, err_data_control_field} <= b;
    repeat (n) @(posedge core_clk);
    {err_clk0, err_clk1, err_data_control_field} <= 3'h0;
    look(4, 8'h00, 0);
    look(4, 8'h01, 1);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'h1;
    for (i = 0; i < 8; i++) rdc(adr[i], rv[i]);
    rdc(8'h42, 8'h00);
    look(1, 8'h80, 1);
    look(2, 8'h30, 0);
    look(3, 8'h88, 0);
    for (i = 0; i < 8; i++) begin
      v = rnd();
      i_lcr_host.acc(1'h1, adr[i], v[7:0]);
      rdc(adr[i], v[7:0]);
    end
    $display("registers done");
    for (i = 0; i < 16; i++) begin
      v = rnd();
      m = i[2:0];
      @(posedge core_clk);
      {spi_ss_n, miso_out_in} <= {v[8], v[9]};
      i_lcr_host.acc(1'h1, 8'h43, {3'h0, v[4:3], m});
      i_lcr_host.acc(1'h1, 8'h44, v[7:0]);
      look(1, {!m[2], !m[2] && m != 3'h0, m[2] ? 3'h0 : (m == 3'h3 ? 3'h4 : m), m[2], m[2] & m[0], m[2] & m[1]}, 3);
      look(2, {1'h0, v[7:5], v[3:1], v[0]}, 0);
      if (m[2] & m[0]) look(6, {5'h0, v[9], v[3], v[4] & v[8]}, 0);
    end
    $display("modes done");
    @(posedge core_clk);
    second_port_access <= 1'h1;
    i_lcr_host.acc(1'h1, 8'h45, 8'h05);
    @(posedge core_clk);
    second_port_access <= 1'h0;
    i_lcr_host.acc(1'h1, 8'h45, 8'h0C);
    look(3, 8'h5C, 2);
    rdc(8'h45, 8'h0C);
    @(posedge core_clk);
    {second_port_access, floor_override_on} <= 2'h3;
    rdc(8'h45, 8'h05);
    $display("floors done");
    for (i = 0; i < 4; i++) begin
      v = rnd();
      @(posedge core_clk);
      {first_rx_input, second_rx_input, floor_apply} <= {v[0], v[1], i[0]};
      i_lcr_host.acc(1'h1, 8'h56, 8'h08);
      i_lcr_host.acc(1'h1, 8'h52, {i[1], 7'h0});
      i_lcr_host.acc(1'h1, 8'h57, {5'h0, i[1], !i[1], 1'h0});
      look(5, {4'h0, i[0], v[i[1]], 2'h2}, 2);
    end
    @(posedge core_clk);
    floor_override_on <= 1'h0;
    i_lcr_host.acc(1'h1, 8'h56, 8'h00);
    look(5, 8'h00, 2);
    i_lcr_host.acc(1'h1, 8'h57, 8'h02);
    look(5, 8'h01, 2);
    $display("loop done");
    @(posedge core_clk);
    clk_en <= 1'h0;
    i_lcr_host.acc(1'h1, 8'h56, 8'h08);
    clk_en <= 1'h1;
    rdc(8'h56, 8'h00);
    $display("freeze done");
    i_lcr_host.acc(1'h1, 8'h41, 8'h13);
    burst(3'h4, 3);
    burst(3'h7, 1);
    @(posedge core_clk);
    err_clk0 <= 1'h1;
    repeat (2) @(posedge core_clk);
    {err_clk0, lock_regained} <= 2'h1;
    @(posedge core_clk);
    {err_clk0, lock_regained} <= 2'h2;
    repeat (2) @(posedge core_clk);
    err_clk0 <= 1'h0;
    look(4, 8'h00, 0);
    look(4, 8'h00, 1);
    i_lcr_host.acc(1'h1, 8'h41, 8'h03);
    burst(3'h2, 1);
    $display("lock drop done");
    conclude();
  end
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
  task conclude();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
endmodule // tb
